// ==== hw/floppy_pins_defs.vh ====
`ifndef FLOPPY_PINS_DEFS_VH
`define FLOPPY_PINS_DEFS_VH

// APB register byte offsets
`define OFS_DOR 12'h000
`define OFS_DIR 12'h004
`define OFS_MODE 12'h008
`define OFS_XFER 12'h00C

// Digital output register fields
`define DOR_DMAEN_BIT 3
`define DOR_HEAD_BIT 4
`define DOR_RESET 8'h00

// Mode register fields
`define MODE_SYS_LO 0
`define MODE_SYS_HI 1
`define MODE_READ_GATE_DIAG_IN_BIT 2
`define MODE_PPM_BIT 3
`define MODE_PNF_BIT 4
`define MODE_RESET 5'h00

// System modes
`define SYS_AT 2'h0
`define SYS_M30 2'h1
`define SYS_ALT 2'h2

// Digital input register fields
`define DIR_CHG_BIT 7
`define DIR_CHG2_BIT 6
`define DIR_READ_GATE_DIAG_IN_BIT 0

// Transfer register fields
`define XFER_PEND_BIT 8
`define XFER_DIR_BIT 9

`endif

// ==== hw/dma_handshake.v ====
`include "floppy_pins_defs.vh"

module dma_handshake (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Control
    input wire dmaEnable,
    input wire byteLoad,
    // DMA pins
    input wire dma_grant_n,
    input wire rdStrobe_n,
    input wire wrStrobe_n,
    // Status
    output reg pending,
    output reg byteDone,
    output wire dma_request_out
);
    reg strobeSeen;
    wire granted;
    wire strobeActive;

    // Grant ignored while disabled, so programmed I/O stays unaffected
    assign granted = dmaEnable && !dma_grant_n;
    assign strobeActive = granted && (!rdStrobe_n || !wrStrobe_n);
    assign dma_request_out = dmaEnable && pending;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
            strobeSeen <= 1'b0;
            byteDone <= 1'b0;
        end else begin
            byteDone <= 1'b0;
            if (strobeActive) begin
                strobeSeen <= 1'b1;
            end else if (strobeSeen) begin
                // Strobe release ends the byte
                strobeSeen <= 1'b0;
                pending <= 1'b0;
                byteDone <= 1'b1;
            end
            if (byteLoad) begin
                pending <= 1'b1;
            end
        end
    end
endmodule // dma_handshake

// ==== hw/floppy_drive_dma_signals.v ====
// Our own choices: the APB slave port and the register offsets.
`include "floppy_pins_defs.vh"

// Operation
// - The door-open input is sampled and readable in the digital input register.
// - A mode bit turns the door-open input into a read-gate diagnostic input instead.
// - In parallel drive mode with routing flag 0 a second door-open input is accepted.
// - Head side select is driven active for side 1 and inactive for side 0.
// - In parallel drive mode with routing flag 0 head side select is also driven out.
// - DMA request goes high whenever a byte needs moving.
// - A low grant lets the read and write strobes act as DMA strobes.
// - In the two legacy modes request and grant work only while output bit D3 is set.
// - In the alternate system mode request and grant are always enabled and D3 is ignored.
module floppy_drive_dma_signals (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Drive pins
    input wire door_opened_in,
    input wire ppDoorOpenedIn,
    output reg head_side_select,
    output reg ppHeadSideSelect,
    output reg ppHeadSideSelectOe,
    // DMA pins
    input wire dma_grant_n,
    input wire rdStrobe_n,
    input wire wrStrobe_n,
    output wire dma_request_out,
    // Diagnostic
    output reg read_gate_diag_in
);
    reg [7:0] digital_output_register;
    reg [4:0] modeReg;
    reg doorSample;
    reg ppDoorSample;
    reg [7:0] xferData;
    reg xferDir;
    reg byteLoad;
    wire pending;
    wire byteDone;
    wire [1:0] sysMode;
    wire rgateSel;
    wire parallel_drive_mode;
    wire drive_routing_flag;
    wire ppRoute;
    wire dmaEnable;
    wire apbWrite;
    wire apbRead;
    wire mapped;

    assign sysMode = modeReg[`MODE_SYS_HI:`MODE_SYS_LO];
    assign rgateSel = modeReg[`MODE_READ_GATE_DIAG_IN_BIT];
    assign parallel_drive_mode = modeReg[`MODE_PPM_BIT];
    assign drive_routing_flag = modeReg[`MODE_PNF_BIT];
    assign ppRoute = parallel_drive_mode && !drive_routing_flag;

    // D3 gates in every system mode except the alternate one
    assign dmaEnable = (sysMode == `SYS_ALT) ? 1'b1 :
        digital_output_register[`DOR_DMAEN_BIT];

    // Zero wait state slave
    assign pready = 1'b1;
    assign mapped = (paddr == `OFS_DOR) || (paddr == `OFS_DIR) ||
        (paddr == `OFS_MODE) || (paddr == `OFS_XFER);
    assign pslverr = psel && penable && !mapped;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !penable && !pwrite;

    dma_handshake uDma (
        .clk_sys(clk_sys),
        .rst(rst),
        .dmaEnable(dmaEnable),
        .byteLoad(byteLoad),
        .dma_grant_n(dma_grant_n),
        .rdStrobe_n(rdStrobe_n),
        .wrStrobe_n(wrStrobe_n),
        .pending(pending),
        .byteDone(byteDone),
        .dma_request_out(dma_request_out)
    );

    // Pin sampling
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            doorSample <= 1'b0;
            ppDoorSample <= 1'b0;
            read_gate_diag_in <= 1'b0;
        end else begin
            if (rgateSel) begin
                read_gate_diag_in <= door_opened_in;
                doorSample <= 1'b0;
            end else begin
                read_gate_diag_in <= 1'b0;
                doorSample <= door_opened_in;
            end
            // Second input ignored unless routed, pin may carry printer traffic
            ppDoorSample <= ppRoute ? ppDoorOpenedIn : 1'b0;
        end
    end

    // Head select outputs
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            head_side_select <= 1'b0;
            ppHeadSideSelect <= 1'b0;
            ppHeadSideSelectOe <= 1'b0;
        end else begin
            head_side_select <= digital_output_register[`DOR_HEAD_BIT];
            ppHeadSideSelect <= ppRoute && digital_output_register[`DOR_HEAD_BIT];
            ppHeadSideSelectOe <= ppRoute;
        end
    end

    // Register writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            digital_output_register <= `DOR_RESET;
            modeReg <= `MODE_RESET;
            xferData <= 8'h00;
            xferDir <= 1'b0;
            byteLoad <= 1'b0;
        end else begin
            byteLoad <= 1'b0;
            if (apbWrite) begin
                if (paddr == `OFS_DOR) begin
                    digital_output_register <= pwdata[7:0];
                end else if (paddr == `OFS_MODE) begin
                    modeReg <= pwdata[4:0];
                end else if (paddr == `OFS_XFER) begin
                    xferData <= pwdata[7:0];
                    xferDir <= pwdata[`XFER_DIR_BIT];
                    byteLoad <= 1'b1;
                end
            end
        end
    end

    // Read data registered in setup, valid during access
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (apbRead) begin
            if (paddr == `OFS_DOR) begin
                prdata <= {24'h000000, digital_output_register};
            end else if (paddr == `OFS_DIR) begin
                prdata <= {24'h000000, doorSample, ppDoorSample, 5'h00,
                    read_gate_diag_in};
            end else if (paddr == `OFS_MODE) begin
                prdata <= {27'h0, modeReg};
            end else if (paddr == `OFS_XFER) begin
                prdata <= {22'h0, xferDir, pending, xferData};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Completion pulse only clears pending; software polls XFER
    wire unusedDone;
    assign unusedDone = byteDone;
endmodule // floppy_drive_dma_signals

// ==== verification/dma_ctl_model.sv ====
module dma_ctl_model (
    input wire clk_sys, rst, dma_request_out, hold,
    output reg dma_grant_n, rdStrobe_n, wrStrobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    bit dir = 0;
    initial begin
        {dma_grant_n, rdStrobe_n, wrStrobe_n} = 3'b111; // Idle between bytes
        forever begin
            @(posedge clk_sys);
            if (!rst && !hold && dma_request_out) begin
                repeat ($urandom_range(3)) @(posedge clk_sys);
                {dma_grant_n, rdStrobe_n, wrStrobe_n} <= dir ? 3'b001 : 3'b010;
                dir = !dir;
                @(posedge clk_sys);
                {dma_grant_n, rdStrobe_n, wrStrobe_n} <= 3'b111;
                repeat (2) @(posedge clk_sys); // Request drops on the first of these two edges
            end
        end
    end
endmodule // dma_ctl_model

// ==== verification/floppy_drive_dma_signals_chk.sv ====
module floppy_drive_dma_signals_chk (
    input wire clk_sys, rst, psel, penable, pwrite, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire door_opened_in, head_side_select, ppHeadSideSelect, ppHeadSideSelectOe,
    input wire dma_grant_n, rdStrobe_n, wrStrobe_n, dma_request_out, read_gate_diag_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire acc = psel && penable && pwrite;
    // Register write lands one edge, the pin follows one edge later
    AST_HEAD_W: assert property (acc && paddr == 12'h000 |-> ##2 head_side_select == $past(pwdata[4], 2))
        else $error("head side not taken from write");
    AST_HEAD_HOLD: assert property ($changed(head_side_select) |-> $past(acc && paddr == 12'h000, 2))
        else $error("head side changed without write");
    AST_PP_OFF: assert property (!ppHeadSideSelectOe |-> !ppHeadSideSelect)
        else $error("parallel head side driven while not routed");
    AST_PP_COPY: assert property (ppHeadSideSelectOe && $stable(head_side_select) |-> ppHeadSideSelect == head_side_select)
        else $error("parallel head side differs");
    AST_REQ_DROP: assert property (dma_request_out && !dma_grant_n && !(rdStrobe_n && wrStrobe_n) ##1 dma_grant_n |=> !dma_request_out)
        else $error("request kept after byte");
    // Enable writes act at once, a byte load one edge later
    AST_REQ_RISE: assert property ($rose(dma_request_out) |-> $past(acc) || $past(acc, 2))
        else $error("request rose without cause");
    AST_READ_GATE_DIAG_IN: assert property (read_gate_diag_in |-> $past(door_opened_in))
        else $error("read gate without pin");
    AST_ERR: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access not refused");
    COV_GRANT: cover property (!dma_grant_n && !rdStrobe_n);
    COV_DROP: cover property ($fell(dma_request_out));
    COV_ERR: cover property (pslverr);
endmodule // floppy_drive_dma_signals_chk
bind floppy_drive_dma_signals floppy_drive_dma_signals_chk chk (.*);

// ==== verification/tb_floppy_drive_dma_signals.sv ====
module tb_floppy_drive_dma_signals;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, door = 0, ppDoor = 0, hold = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, md, d;
    logic pready, pslverr, err, head_side_select, ppHeadSideSelect, ppHeadSideSelectOe;
    logic dma_grant_n, rdStrobe_n, wrStrobe_n, dma_request_out, read_gate_diag_in;
    int fails = 0, samples_checked = 0, m, w;
    bit en;
    floppy_drive_dma_signals uut (.*, .door_opened_in(door), .ppDoorOpenedIn(ppDoor));
    dma_ctl_model partner (.*);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, v};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(6109));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (m = 0; m < 8; m++) begin
            // Every system mode with enable bit clear and set
            d = ($urandom_range(1) << 4) | ((m & 1) << 3);
            md = (m >> 1) | ($urandom_range(7) << 2);
            door <= 1'($urandom_range(1));
            ppDoor <= 1'($urandom_range(1));
            apb(1, 12'h008, md);
            apb(1, 12'h000, d);
            apb(1, 12'h00C, $urandom_range(255));
            en = (m >> 1) == 2 || (m & 1);
            // Pending lands one edge after the load pulse
            repeat (2) @(posedge clk_sys);
            chk(dma_request_out, en);
            chk(head_side_select, d[4]);
            chk(ppHeadSideSelectOe, md[3] & !md[4]);
            chk(read_gate_diag_in, md[2] & door);
            apb(0, 12'h004, 0);
            if (!md[2]) chk(rd[7], door);
            if (md[3] & !md[4]) chk(rd[6], ppDoor);
            hold <= 1'b0;
            @(posedge clk_sys);
            for (w = 0; w < 20 && dma_request_out; w++) @(posedge clk_sys);
            hold <= 1'b1;
            repeat (3) @(posedge clk_sys);
            chk(dma_request_out, 0);
            apb(0, 12'h00C, 0);
            chk(rd[8], !en);
        end
        apb(1, 12'h010, 32'hFF);
        chk(err, 1);
        apb(0, 12'h000, 0);
        chk(rd, d);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({head_side_select, dma_request_out, ppHeadSideSelectOe}, 0);
        stop_test();
    end
endmodule // tb_floppy_drive_dma_signals
